/* File: inc/bbmc_pkg.sv */
// bbmc_pkg: constants, register map and state codes of the boost/bypass mode controller
package bbmc_pkg;
   // clock and time figures
   localparam int CLK_MHZ = 250;
   localparam int REV_DLY_NS = 4000;
   localparam int REV_CYC = (REV_DLY_NS * CLK_MHZ) / 1000;
   localparam int US_MIN_FREQ_HZ = 23000;
   // longest allowed gap rounds down
   localparam int US_GAP_CYC = (CLK_MHZ * 1000000) / US_MIN_FREQ_HZ;
   localparam int PRECHG_MS = 1;
   localparam int PRECHG_CYC = PRECHG_MS * CLK_MHZ * 1000;
   localparam int HICCUP_MS = 19;
   localparam int HICCUP_CYC = HICCUP_MS * CLK_MHZ * 1000;
   localparam logic [2:0] CLAMP_RUN = 3'h7;

   // register byte addresses
   localparam logic [31:0] OFS_CTRL = 32'h0000_0000;
   localparam logic [31:0] OFS_STAT = 32'h0000_0004;

   // control register fields
   localparam int OPM_LSB = 0;
   localparam int LL_LSB = 2;
   localparam int PD_BIT = 4;
   localparam int HIC_BIT = 5;
   localparam int ILIM_LSB = 8;
   localparam logic [1:0] OPM_RST = 2'h1;
   localparam logic [1:0] LL_RST = 2'h0;
   localparam logic PD_RST = 1'h1;
   localparam logic HIC_RST = 1'h1;
   localparam logic [3:0] ILIM_RST = 4'hA;

   // status register fields
   localparam int ST_LSB = 0;
   localparam int UVLO_BIT = 4;
   localparam int REVB_BIT = 5;
   localparam int BYPSW_BIT = 6;
   localparam int CLAMP_LSB = 8;

   // operating-mode field codes
   localparam logic [1:0] OPM_AUTO_A = 2'h0;
   localparam logic [1:0] OPM_AUTO = 2'h1;
   localparam logic [1:0] OPM_FBYP = 2'h2;
   localparam logic [1:0] OPM_RSHD = 2'h3;
   // light-load field codes; 10 and 11 both mean forced pulse-width
   localparam logic [1:0] LL_PFM = 2'h0;
   localparam logic [1:0] LL_US = 2'h1;

   // synchroniser bit positions
   localparam int IX_EN = 0;
   localparam int IX_UVF = 1;
   localparam int IX_UVR = 2;
   localparam int IX_T1 = 3;
   localparam int IX_T2 = 4;
   localparam int IX_VIVO = 5;
   localparam int IX_M50 = 6;
   localparam int IX_OCP = 7;
   localparam int IX_REV = 8;
   localparam int IX_DCM = 9;
   localparam int IX_PRE = 10;
   localparam int IX_SW = 11;
   localparam int IX_CLMP = 12;
   localparam int NSYNC = 13;

   typedef enum logic [2:0] {
      ST_OFF = 3'h0,
      ST_PRECHG = 3'h1,
      ST_BOOST = 3'h2,
      ST_BYPASS = 3'h3,
      ST_FBYP = 3'h4,
      ST_FAULT = 3'h5
   } bbmc_state_e;
endpackage

/* File: verilog/bbmc_ctrl.sv */
// bbmc_ctrl: boost/bypass mode controller with AHB-Lite register slave
// Behaviour
// - enable high and mode 01 (reset value) runs automatic boost/bypass.
// - mode 00 or 01 both select automatic boost/bypass; bypass tracks input.
// - enable high, mode 10 holds forced bypass with current-limited bypass switch on.
// - enable high, mode 11 turns power stage off; registers stay reachable.
// - enable pin low forces full shutdown over every mode setting.
// - in both shutdowns every switch path stays open.
// - input above target gives zero duty with bypass switch fully on.
// - pulse-frequency or ultrasonic: bypass entry needs output above target+1% and input above output.
// - forced pulse-width: bypass entry on output above target+2% or seven clamped off-times.
// - output below target minus 50mV leaves bypass for boost.
// - bypass overcurrent opens switch, enters short protection, restarts only if the fault is clear when the hiccup wait ends.
// - output 20mV over input for about 4us in bypass opens bypass switch.
// - light-load field 00 selects pulse-frequency, 10 or 11 forced pulse-width.
// - pulse-frequency falls back to pulse-width when discontinuous current is insufficient.
// - forced pulse-width keeps high-side on through negative current.
// - ultrasonic forces extra cycles so switching never falls below 23kHz.
// - pull-down on in either shutdown only while discharge bit is set.
// - undervoltage disables register interface and output stage until input recovers.
// - precharge failing within 1ms faults, waits 19ms, retries unless disabled.
module bbmc_ctrl #(
   parameter int US_GAP = bbmc_pkg::US_GAP_CYC,
   parameter int PRECHG = bbmc_pkg::PRECHG_CYC,
   parameter int HICCUP = bbmc_pkg::HICCUP_CYC
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic en_pin,
   input wire logic vin_uvlo_fall,
   input wire logic vin_uvlo_rise,
   input wire logic vout_gt_tar_1pct,
   input wire logic vout_gt_tar_2pct,
   input wire logic vin_gt_vout,
   input wire logic vout_lt_tar_m50,
   input wire logic bypass_ocp,
   input wire logic vout_gt_vin_20mv,
   input wire logic dcm_limit,
   input wire logic precharge_done,
   input wire logic sw_cycle,
   input wire logic off_time_clamp,
   output logic bypass_sw_en,
   output logic boost_sw_en,
   output logic precharge_en,
   output logic hs_neg_keep,
   output logic dcm_allow,
   output logic force_cycle,
   output logic output_pulldown_enable,
   output logic [3:0] bypass_ilim
);
   localparam int TMAX = (PRECHG > HICCUP) ? PRECHG : HICCUP;
   localparam int TW = $clog2(TMAX + 1);
   localparam int UW = $clog2(US_GAP + 1);
   localparam int RW = $clog2(bbmc_pkg::REV_CYC + 1);

   generate
      if (US_GAP < 2 || PRECHG < 2 || HICCUP < 2) begin : g_chk
         $error("bbmc_ctrl: timing counts must be at least 2");
      end
   endgenerate

   // synchronisers
   logic [bbmc_pkg::NSYNC-1:0] raw;
   logic [bbmc_pkg::NSYNC-1:0] s1_r;
   logic [bbmc_pkg::NSYNC-1:0] s2_r;
   assign raw = {off_time_clamp, sw_cycle, precharge_done, dcm_limit, vout_gt_vin_20mv,
                 bypass_ocp, vout_lt_tar_m50, vin_gt_vout, vout_gt_tar_2pct,
                 vout_gt_tar_1pct, vin_uvlo_rise, vin_uvlo_fall, en_pin};
   genvar gi;
   generate
      for (gi = 0; gi < bbmc_pkg::NSYNC; gi++) begin : g_sync
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_r[gi] <= 1'h0;
               s2_r[gi] <= 1'h0;
            end else begin
               s1_r[gi] <= raw[gi];
               s2_r[gi] <= s1_r[gi];
            end
         end
      end
   endgenerate

   logic en_s, t1_s, t2_s, vivo_s, m50_s, ocp_s, rev_s, dcm_s, pre_s, sw_s, clmp_s;
   assign en_s = s2_r[bbmc_pkg::IX_EN];
   assign t1_s = s2_r[bbmc_pkg::IX_T1];
   assign t2_s = s2_r[bbmc_pkg::IX_T2];
   assign vivo_s = s2_r[bbmc_pkg::IX_VIVO];
   assign m50_s = s2_r[bbmc_pkg::IX_M50];
   assign ocp_s = s2_r[bbmc_pkg::IX_OCP];
   assign rev_s = s2_r[bbmc_pkg::IX_REV];
   assign dcm_s = s2_r[bbmc_pkg::IX_DCM];
   assign pre_s = s2_r[bbmc_pkg::IX_PRE];
   assign sw_s = s2_r[bbmc_pkg::IX_SW];
   assign clmp_s = s2_r[bbmc_pkg::IX_CLMP];

   // undervoltage lockout, locked from power-on until input is seen good
   logic uvlo_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         uvlo_r <= 1'h1;
      end else if (s2_r[bbmc_pkg::IX_UVF]) begin
         uvlo_r <= 1'h1;
      end else if (s2_r[bbmc_pkg::IX_UVR]) begin
         uvlo_r <= 1'h0;
      end
   end

   // control register
   logic [1:0] opm_r;
   logic [1:0] ll_r;
   logic pd_r;
   logic hic_r;
   logic [3:0] ilim_r;
   logic dwr_r;
   logic [31:0] daddr_r;
   logic [31:0] hrdata_r;
   bbmc_pkg::bbmc_state_e st_r;
   logic rev_block_r;
   logic [2:0] clamp_r;
   logic byp_on_r;

   logic aph;
   assign aph = hsel && htrans[1] && hready;
   assign hreadyout = 1'h1;
   assign hresp = 1'h0;
   assign hrdata = hrdata_r;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dwr_r <= 1'h0;
         daddr_r <= 32'h0;
      end else begin
         dwr_r <= aph && hwrite;
         daddr_r <= haddr;
      end
   end

   // interface held dead during lockout: writes dropped, reads zero
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opm_r <= bbmc_pkg::OPM_RST;
         ll_r <= bbmc_pkg::LL_RST;
         pd_r <= bbmc_pkg::PD_RST;
         hic_r <= bbmc_pkg::HIC_RST;
         ilim_r <= bbmc_pkg::ILIM_RST;
      end else if (dwr_r && !uvlo_r && daddr_r == bbmc_pkg::OFS_CTRL) begin
         opm_r <= hwdata[bbmc_pkg::OPM_LSB +: 2];
         ll_r <= hwdata[bbmc_pkg::LL_LSB +: 2];
         pd_r <= hwdata[bbmc_pkg::PD_BIT];
         hic_r <= hwdata[bbmc_pkg::HIC_BIT];
         ilim_r <= hwdata[bbmc_pkg::ILIM_LSB +: 4];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0;
      end else if (aph && !hwrite && !uvlo_r) begin
         hrdata_r <= 32'h0;
         if (haddr == bbmc_pkg::OFS_CTRL) begin
            hrdata_r[bbmc_pkg::OPM_LSB +: 2] <= opm_r;
            hrdata_r[bbmc_pkg::LL_LSB +: 2] <= ll_r;
            hrdata_r[bbmc_pkg::PD_BIT] <= pd_r;
            hrdata_r[bbmc_pkg::HIC_BIT] <= hic_r;
            hrdata_r[bbmc_pkg::ILIM_LSB +: 4] <= ilim_r;
         end else if (haddr == bbmc_pkg::OFS_STAT) begin
            hrdata_r[bbmc_pkg::ST_LSB +: 3] <= st_r;
            hrdata_r[bbmc_pkg::UVLO_BIT] <= uvlo_r;
            hrdata_r[bbmc_pkg::REVB_BIT] <= rev_block_r;
            hrdata_r[bbmc_pkg::BYPSW_BIT] <= byp_on_r;
            hrdata_r[bbmc_pkg::CLAMP_LSB +: 3] <= clamp_r;
         end
      end else if (aph) begin
         hrdata_r <= 32'h0;
      end
   end

   // mode decode
   logic shd;
   logic fpwm;
   logic autom;
   logic byp_enter;
   assign shd = uvlo_r || !en_s || (opm_r == bbmc_pkg::OPM_RSHD);
   assign autom = (opm_r == bbmc_pkg::OPM_AUTO) || (opm_r == bbmc_pkg::OPM_AUTO_A);
   assign fpwm = ll_r[1];
   // forced pulse-width uses its own wider margin and the clamp run
   assign byp_enter = fpwm ? (t2_s || clamp_r == bbmc_pkg::CLAMP_RUN)
                           : (t1_s && vivo_s);

   // shared precharge / hiccup timer; restarts whenever the state changes
   bbmc_pkg::bbmc_state_e st_d_r;
   logic [TW-1:0] tmr_r;
   logic fresh;
   logic pre_to;
   logic hic_done;
   assign fresh = (st_r != st_d_r);
   assign pre_to = !fresh && tmr_r == TW'(PRECHG - 1);
   assign hic_done = !fresh && tmr_r == TW'(HICCUP - 1);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_d_r <= bbmc_pkg::ST_OFF;
         tmr_r <= '0;
      end else begin
         st_d_r <= st_r;
         if (fresh) begin
            tmr_r <= '0;
         end else if (tmr_r != TW'(TMAX)) begin
            tmr_r <= tmr_r + TW'(1);
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= bbmc_pkg::ST_OFF;
      end else if (shd) begin
         st_r <= bbmc_pkg::ST_OFF;
      end else begin
         case (st_r)
            bbmc_pkg::ST_OFF: begin
               if (opm_r == bbmc_pkg::OPM_FBYP) begin
                  st_r <= bbmc_pkg::ST_FBYP;
               end else begin
                  st_r <= bbmc_pkg::ST_PRECHG;
               end
            end
            bbmc_pkg::ST_PRECHG: begin
               if (opm_r == bbmc_pkg::OPM_FBYP) begin
                  st_r <= bbmc_pkg::ST_FBYP;
               end else if (pre_s) begin
                  st_r <= bbmc_pkg::ST_BOOST;
               end else if (pre_to) begin
                  st_r <= bbmc_pkg::ST_FAULT;
               end
            end
            bbmc_pkg::ST_BOOST: begin
               if (opm_r == bbmc_pkg::OPM_FBYP) begin
                  st_r <= bbmc_pkg::ST_FBYP;
               end else if (autom && byp_enter) begin
                  st_r <= bbmc_pkg::ST_BYPASS;
               end
            end
            bbmc_pkg::ST_BYPASS: begin
               if (opm_r == bbmc_pkg::OPM_FBYP) begin
                  st_r <= bbmc_pkg::ST_FBYP;
               end else if (ocp_s) begin
                  st_r <= bbmc_pkg::ST_FAULT;
               end else if (m50_s) begin
                  st_r <= bbmc_pkg::ST_BOOST;
               end
            end
            bbmc_pkg::ST_FBYP: begin
               if (opm_r != bbmc_pkg::OPM_FBYP) begin
                  st_r <= bbmc_pkg::ST_PRECHG;
               end else if (ocp_s) begin
                  st_r <= bbmc_pkg::ST_FAULT;
               end
            end
            bbmc_pkg::ST_FAULT: begin
               // with retry disabled the fault holds until a shutdown
               if (hic_r && hic_done && !ocp_s) begin
                  st_r <= bbmc_pkg::ST_PRECHG;
               end
            end
            default: begin
               st_r <= bbmc_pkg::ST_OFF;
            end
         endcase
      end
   end

   // consecutive clamped off-time cycles, counted at each cycle start
   logic sw_d_r;
   logic sw_start;
   assign sw_start = sw_s && !sw_d_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sw_d_r <= 1'h0;
         clamp_r <= 3'h0;
      end else begin
         sw_d_r <= sw_s;
         if (st_r != bbmc_pkg::ST_BOOST || !fpwm) begin
            clamp_r <= 3'h0;
         end else if (sw_start) begin
            if (!clmp_s) begin
               clamp_r <= 3'h0;
            end else if (clamp_r != bbmc_pkg::CLAMP_RUN) begin
               clamp_r <= clamp_r + 3'h1;
            end
         end
      end
   end

   // reverse-current blocking in bypass
   logic [RW-1:0] rev_cnt_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rev_cnt_r <= '0;
         rev_block_r <= 1'h0;
      end else if (st_r != bbmc_pkg::ST_BYPASS || !rev_s) begin
         rev_cnt_r <= '0;
         rev_block_r <= 1'h0;
      end else if (rev_cnt_r == RW'(bbmc_pkg::REV_CYC - 1)) begin
         rev_block_r <= 1'h1;
      end else begin
         rev_cnt_r <= rev_cnt_r + RW'(1);
      end
   end

   // ultrasonic floor: a forced cycle when no natural one arrives in time
   logic [UW-1:0] us_gap_r;
   logic force_r;
   logic us_on;
   assign us_on = (st_r == bbmc_pkg::ST_BOOST) && (ll_r == bbmc_pkg::LL_US);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         us_gap_r <= '0;
         force_r <= 1'h0;
      end else if (!us_on || sw_start || us_gap_r == UW'(US_GAP - 1)) begin
         us_gap_r <= '0;
         force_r <= us_on && !sw_start && us_gap_r == UW'(US_GAP - 1);
      end else begin
         us_gap_r <= us_gap_r + UW'(1);
         force_r <= 1'h0;
      end
   end

   // registered switch and discharge drives
   logic boost_r, pre_r, hsn_r, dcm_r, pd_out_r;
   logic [3:0] ilim_o_r;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         byp_on_r <= 1'h0;
         boost_r <= 1'h0;
         pre_r <= 1'h0;
         hsn_r <= 1'h0;
         dcm_r <= 1'h0;
         pd_out_r <= 1'h0;
         ilim_o_r <= bbmc_pkg::ILIM_RST;
      end else begin
         byp_on_r <= (st_r == bbmc_pkg::ST_FBYP) ||
                     (st_r == bbmc_pkg::ST_BYPASS && !rev_block_r);
         boost_r <= (st_r == bbmc_pkg::ST_BOOST);
         pre_r <= (st_r == bbmc_pkg::ST_PRECHG);
         hsn_r <= (st_r == bbmc_pkg::ST_BOOST) && fpwm;
         dcm_r <= (st_r == bbmc_pkg::ST_BOOST) && ll_r == bbmc_pkg::LL_PFM && !dcm_s;
         pd_out_r <= pd_r && (!en_s || opm_r == bbmc_pkg::OPM_RSHD);
         ilim_o_r <= ilim_r;
      end
   end
   assign bypass_sw_en = byp_on_r;
   assign boost_sw_en = boost_r;
   assign precharge_en = pre_r;
   assign hs_neg_keep = hsn_r;
   assign dcm_allow = dcm_r;
   assign force_cycle = force_r;
   assign output_pulldown_enable = pd_out_r;
   assign bypass_ilim = ilim_o_r;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   en_low_off_a: assert property (!en_s |=> st_r == bbmc_pkg::ST_OFF)
      else $error("enable low did not force shutdown");
   reg_shdn_a: assert property (opm_r == bbmc_pkg::OPM_RSHD |=> st_r == bbmc_pkg::ST_OFF)
      else $error("mode 11 did not force shutdown");
   shdn_paths_a: assert property (st_r == bbmc_pkg::ST_OFF |=> !bypass_sw_en && !boost_sw_en
                                  && !precharge_en)
      else $error("switch path driven in shutdown");
   fbyp_switch_a: assert property (st_r == bbmc_pkg::ST_FBYP |=> bypass_sw_en)
      else $error("forced bypass switch not on");
   auto_entry_a: assert property (st_r == bbmc_pkg::ST_BOOST && !shd && autom && !fpwm
                                  && t1_s && vivo_s |=> st_r == bbmc_pkg::ST_BYPASS)
      else $error("bypass entry missed in light-load mode");
   pwm_clamp_a: assert property (st_r == bbmc_pkg::ST_BOOST && !shd && autom && fpwm
                                 && clamp_r == bbmc_pkg::CLAMP_RUN
                                 |=> st_r == bbmc_pkg::ST_BYPASS)
      else $error("seven clamped cycles did not enter bypass");
   byp_exit_a: assert property (st_r == bbmc_pkg::ST_BYPASS && !shd && autom && !ocp_s
                                && m50_s |=> st_r == bbmc_pkg::ST_BOOST)
      else $error("bypass exit missed");
   ocp_trip_a: assert property (st_r == bbmc_pkg::ST_BYPASS && !shd && autom && ocp_s
                                |=> st_r == bbmc_pkg::ST_FAULT ##1 !bypass_sw_en)
      else $error("overcurrent did not open bypass");
   rev_block_a: assert property ($rose(rev_block_r) |-> $past(rev_s, 2)
                                 ##1 (!bypass_sw_en || !rev_block_r))
      else $error("reverse block without cause or switch left on");
   pulldown_a: assert property (!en_s && pd_r |=> output_pulldown_enable)
      else $error("pull-down not enabled in shutdown");
   us_floor_a: assert property (us_on && !sw_start && us_gap_r == UW'(US_GAP - 1)
                                |=> force_cycle)
      else $error("ultrasonic floor cycle not forced");
   uvlo_off_a: assert property (uvlo_r |=> st_r == bbmc_pkg::ST_OFF ##1 !bypass_sw_en)
      else $error("output stage active during lockout");
endmodule // bbmc_ctrl

/* File: testbench/bbmc_stage_model.sv */
// bbmc_stage_model: behavioural power stage and comparators facing the mode controller
module bbmc_stage_model (
   input wire logic hclk,
   input wire logic precharge_en,
   input wire logic boost_sw_en,
   input wire logic force_cycle,
   input wire logic vin_high,
   input wire logic droop,
   input wire logic pre_stall,
   input wire logic light,
   output logic precharge_done,
   output logic vout_gt_tar_1pct,
   output logic vout_gt_tar_2pct,
   output logic vin_gt_vout,
   output logic vout_lt_tar_m50,
   output logic sw_cycle
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] pre_cnt_r = 3'h0;
   logic [2:0] ph_r = 3'h0;
   logic echo_r = 1'b0;
   // battery above target lifts the output past both entry margins
   assign vout_gt_tar_1pct = vin_high;
   assign vout_gt_tar_2pct = vin_high;
   assign vin_gt_vout = vin_high;
   assign vout_lt_tar_m50 = droop;
   // a stalled precharge never gets the output up to the input
   assign precharge_done = pre_cnt_r > 3'h4;
   // at light load only forced cycles show up as switching
   assign sw_cycle = light ? echo_r : ph_r[2];
   always @(posedge hclk) begin
      if (!precharge_en)
         pre_cnt_r <= 3'h0;
      else if (!pre_stall && !precharge_done)
         pre_cnt_r <= pre_cnt_r + 3'h1;
      ph_r <= boost_sw_en ? ph_r + 3'h1 : 3'h0;
      echo_r <= force_cycle;
   end
endmodule // bbmc_stage_model

/* File: testbench/tb_boost_bypass_mode_control.sv */
// tb_boost_bypass_mode_control: self-checking bench of the mode controller
module tb_boost_bypass_mode_control;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct packed {
      logic en;
      logic [11:0] ctrl;
      logic vh;
      logic dr;
      logic [2:0] st;
      logic byp;
      logic bst;
      logic pd;
      logic hsn;
   } bbmc_row_s;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic hready, hreadyout, hresp;
   logic en_pin = 1'b0, vin_uvlo_fall = 1'b1, vin_uvlo_rise = 1'b0;
   logic vin_high = 1'b0, droop = 1'b0, pre_stall = 1'b0, light = 1'b0;
   logic bypass_ocp = 1'b0, vout_gt_vin_20mv = 1'b0, dcm_limit = 1'b0, off_time_clamp = 1'b0;
   logic vout_gt_tar_1pct, vout_gt_tar_2pct, vin_gt_vout, vout_lt_tar_m50;
   logic precharge_done, sw_cycle, bypass_sw_en, boost_sw_en, precharge_en;
   logic hs_neg_keep, dcm_allow, force_cycle, output_pulldown_enable;
   logic [3:0] bypass_ilim;
   int errors = 0, n_tests = 0, fc_cnt = 0, fc0 = 0;
   bbmc_row_s rows [12];

   always #2 hclk = ~hclk;
   assign hready = hreadyout;
   always @(posedge hclk) fc_cnt <= fc_cnt + int'(force_cycle === 1'b1);

   // shortened precharge, hiccup and ultrasonic gap keep the run brief
   bbmc_ctrl #(.US_GAP(20), .PRECHG(50), .HICCUP(100)) DUT (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .en_pin, .vin_uvlo_fall, .vin_uvlo_rise,
      .vout_gt_tar_1pct, .vout_gt_tar_2pct, .vin_gt_vout, .vout_lt_tar_m50, .bypass_ocp,
      .vout_gt_vin_20mv, .dcm_limit, .precharge_done, .sw_cycle, .off_time_clamp,
      .bypass_sw_en, .boost_sw_en, .precharge_en, .hs_neg_keep, .dcm_allow, .force_cycle,
      .output_pulldown_enable, .bypass_ilim);
   bbmc_stage_model STAGE (.hclk, .precharge_en, .boost_sw_en, .force_cycle, .vin_high,
      .droop, .pre_stall, .light, .precharge_done, .vout_gt_tar_1pct, .vout_gt_tar_2pct,
      .vin_gt_vout, .vout_lt_tar_m50, .sw_cycle);

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // polls the state field under a bounded count, then compares it
   task automatic st_is(input logic [2:0] st);
      int k;
      k = 0;
      do begin
         ahb(bbmc_pkg::OFS_STAT, 1'b0, 32'h0);
         k++;
      end while (rd[2:0] !== st && k < 400);
      chk("state", 32'(rd[2:0]), 32'(st));
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic close_out;
      if (errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #100000;
      errors++;
      close_out();
   end

   initial begin
      rows[0] = '{1'b1, 12'hA31, 1'b0, 1'b0, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0};
      rows[1] = '{1'b1, 12'hA31, 1'b1, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0};
      rows[2] = '{1'b1, 12'hA30, 1'b0, 1'b1, 3'h2, 1'b0, 1'b1, 1'b0, 1'b0};
      rows[3] = '{1'b1, 12'hA30, 1'b1, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0};
      rows[4] = '{1'b1, 12'h63A, 1'b0, 1'b0, 3'h4, 1'b1, 1'b0, 1'b0, 1'b0};
      rows[5] = '{1'b1, 12'hA33, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[6] = '{1'b1, 12'hA23, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0};
      rows[7] = '{1'b0, 12'hA31, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b1, 1'b0};
      rows[8] = '{1'b1, 12'hA39, 1'b0, 1'b0, 3'h2, 1'b0, 1'b1, 1'b0, 1'b1};
      rows[9] = '{1'b1, 12'hA3D, 1'b0, 1'b0, 3'h2, 1'b0, 1'b1, 1'b0, 1'b1};
      rows[10] = '{1'b1, 12'hA3D, 1'b1, 1'b0, 3'h3, 1'b1, 1'b0, 1'b0, 1'b0};
      rows[11] = '{1'b0, 12'hA23, 1'b0, 1'b0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0};
      cyc(4);
      hresetn <= 1'b1;
      cyc(1);
      chk("ilim_rst", 32'(bypass_ilim), 32'hA);
      ahb(bbmc_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("lock_read", rd, 32'h0);
      vin_uvlo_fall <= 1'b0;
      vin_uvlo_rise <= 1'b1;
      cyc(8);
      ahb(bbmc_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("ctrl_rst", rd, 32'hA31);
      ahb(32'h8, 1'b1, 32'hFFFF_FFFF);
      ahb(32'h8, 1'b0, 32'h0);
      chk("unmapped", rd, 32'h0);
      chk("hresp", 32'(hresp), 32'h0);
      foreach (rows[i]) begin
         en_pin <= rows[i].en;
         vin_high <= rows[i].vh;
         droop <= rows[i].dr;
         ahb(bbmc_pkg::OFS_CTRL, 1'b1, {20'h0, rows[i].ctrl});
         st_is(rows[i].st);
         cyc(4);
         chk("bypass", 32'(bypass_sw_en), 32'(rows[i].byp));
         chk("boost", 32'(boost_sw_en), 32'(rows[i].bst));
         chk("pulldown", 32'(output_pulldown_enable), 32'(rows[i].pd));
         chk("ilim", 32'(bypass_ilim), 32'(rows[i].ctrl[11:8]));
         if (rows[i].st == 3'h2)
            chk("hs_neg", 32'(hs_neg_keep), 32'(rows[i].hsn));
      end
      // six clamped cycles fall one short of the bypass count
      en_pin <= 1'b1;
      ahb(bbmc_pkg::OFS_CTRL, 1'b1, 32'hA39);
      st_is(3'h2);
      @(posedge sw_cycle);
      cyc(1);
      off_time_clamp <= 1'b1;
      repeat (6) @(posedge sw_cycle);
      cyc(1);
      off_time_clamp <= 1'b0;
      cyc(30);
      st_is(3'h2);
      off_time_clamp <= 1'b1;
      st_is(3'h3);
      off_time_clamp <= 1'b0;
      vout_gt_vin_20mv <= 1'b1;
      cyc(980);
      chk("rev_hold", 32'(bypass_sw_en), 32'h1);
      cyc(40);
      chk("rev_block", 32'(bypass_sw_en), 32'h0);
      vout_gt_vin_20mv <= 1'b0;
      cyc(10);
      bypass_ocp <= 1'b1;
      st_is(3'h5);
      chk("ocp_open", 32'(bypass_sw_en), 32'h0);
      bypass_ocp <= 1'b0;
      st_is(3'h2);
      en_pin <= 1'b0;
      pre_stall <= 1'b1;
      ahb(bbmc_pkg::OFS_CTRL, 1'b1, 32'hA11);
      cyc(8);
      en_pin <= 1'b1;
      cyc(8);
      chk("pre_on", 32'(precharge_en), 32'h1);
      st_is(3'h5);
      pre_stall <= 1'b0;
      cyc(300);
      st_is(3'h5);
      en_pin <= 1'b0;
      pre_stall <= 1'b1;
      ahb(bbmc_pkg::OFS_CTRL, 1'b1, 32'hA31);
      cyc(8);
      en_pin <= 1'b1;
      st_is(3'h5);
      pre_stall <= 1'b0;
      st_is(3'h2);
      vin_uvlo_fall <= 1'b1;
      vin_uvlo_rise <= 1'b0;
      cyc(10);
      ahb(bbmc_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("uv_bus", rd, 32'h0);
      chk("uv_boost", 32'(boost_sw_en), 32'h0);
      vin_uvlo_fall <= 1'b0;
      vin_uvlo_rise <= 1'b1;
      st_is(3'h2);
      light <= 1'b1;
      ahb(bbmc_pkg::OFS_CTRL, 1'b1, 32'hA35);
      cyc(20);
      fc0 = fc_cnt;
      cyc(200);
      chk("us_force", 32'(fc_cnt > fc0 + 5), 32'h1);
      ahb(bbmc_pkg::OFS_CTRL, 1'b1, 32'hA31);
      cyc(20);
      fc0 = fc_cnt;
      cyc(200);
      chk("pfm_force", 32'(fc_cnt - fc0), 32'h0);
      chk("dcm_on", 32'(dcm_allow), 32'h1);
      dcm_limit <= 1'b1;
      cyc(10);
      chk("dcm_off", 32'(dcm_allow), 32'h0);
      // mid-run reset relocks until the input is seen good again
      hresetn <= 1'b0;
      cyc(2);
      chk("rst_boost", 32'(boost_sw_en), 32'h0);
      hresetn <= 1'b1;
      cyc(1);
      ahb(bbmc_pkg::OFS_CTRL, 1'b0, 32'h0);
      chk("rst_lock", rd, 32'h0);
      close_out();
   end
endmodule // tb_boost_bypass_mode_control
